// >>> design/epzo_pulse_out.sv
// Divided encoder pulse output: A/B regeneration, phase-Z shaping and
// initial absolute position replay, with an AXI4-Lite register slave.
// Assumes all pins synchronous to core_clk and a single clock domain.
//
// Overview of operation
// - Motor phase Z is stretched by a trim count of 0 to 32767 output pulses.
// - Scale phase Z is held at least a set time of 0 to 400 us.
// - In serial scale mode with interval 0, Z is emitted only at scale position 0.
// - A nonzero interval up to 2^28 repeats Z after the zero-position Z.
// - The interval counts scale phase-A pulses, not quadrature edges.
// - Periodic Z stays off until the scale position has first reached zero.
// - Select 0 passes scale A/B through, select 1 regenerates them in scale A/B mode only; serial scale mode passes them through.
// - Scale phase Z is never regenerated, whatever the select.
// - With regeneration, Z may lead the delayed A/B; the host tolerates it.
// - Replay pulses come at the rate of a 1000 to 3000 r/min motor, default 1000.
// - The replay speed must let replay end before the host's timeout.
// - With the absolute function on, a sensor-on request starts the replay.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
module epzo_pulse_out
    import epzo_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        motorA,
    input  wire logic        motorB,
    input  wire logic        motorZ,
    input  wire logic        scaleA,
    input  wire logic        scaleB,
    input  wire logic        scaleZ,
    input  wire logic [31:0] scalePos,
    input  wire logic [31:0] absPosition,
    input  wire logic        sensorOnRequest,
    output logic             pulseOutA,
    output logic             pulseOutB,
    output logic             pulseOutZ,
    output logic             replayBusy
);
    import epzo_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic regHit(input logic [31:0] a);
        return (a[31:5] == 27'h0000000);
    endfunction : regHit

    function automatic logic [1:0] phaseOf(input logic a, input logic b);
        return {b, a ^ b};
    endfunction : phaseOf

    function automatic logic [31:0] regVal(input epzo_state_t s, input logic [31:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a[4:0])
            REG_CTRL:
            begin
                v[1:0]       = s.outSrc;
                v[CTRL_REGEN] = s.regenSel;
                v[CTRL_ABSEN] = s.absEn;
            end
            REG_Z_TRIM:   v[14:0] = s.zTrim;
            REG_Z_MIN:    v[8:0]  = s.zMinUs;
            REG_Z_INTV:   v[28:0] = s.zIntv;
            REG_RP_SPEED: v[11:0] = s.rpSpeed;
            REG_RP_PPR:   v[17:0] = s.ppr;
            REG_STATUS:
            begin
                v[ST_BUSY]      = (s.rp == RP_RUN);
                v[ST_ZERO_SEEN] = s.zeroSeen;
                v[ST_Z_OUT]     = s.outZ;
                v[ST_RP_DONE]   = s.rpDone;
            end
            REG_RP_LEFT:  v = s.rpLeft[33:2];
            default:      v = 32'h0000_0000;
        endcase
        return v;
    endfunction : regVal

    function automatic logic [31:0] wrMerge(input logic [31:0] o, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction : wrMerge

    epzo_state_t st_r;
    epzo_state_t st_nxt;
    logic        regenOn;
    logic        replayOn;
    logic        zSrc;
    logic        zEvt;
    logic        posZero;
    logic        stepFwd;
    logic        stepRev;
    logic        pulseWrap;
    logic        pulseFwd;
    logic        pulseRev;
    logic [1:0]  curPh;
    logic [1:0]  dPh;
    logic [28:0] zRelN;
    logic [31:0] wrVal;
    logic [31:0] absMag;
    logic [39:0] accSum;
    logic [39:0] rpInc;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt   = st_r;
        replayOn = (st_r.rp == RP_RUN);
        regenOn  = st_r.regenSel && (st_r.outSrc == SRC_SCALE_AB);
        posZero  = (scalePos == 32'h0000_0000);
        curPh    = (st_r.outSrc == SRC_MOTOR) ? phaseOf(motorA, motorB)
                                              : phaseOf(scaleA, scaleB);
        dPh      = curPh - st_r.inPh;
        stepFwd  = (dPh == 2'h1);
        stepRev  = (dPh == 2'h3);
        pulseFwd = stepFwd && (curPh == 2'h0);
        pulseRev = stepRev && (curPh == 2'h3);
        pulseWrap = pulseFwd || pulseRev;
        st_nxt.inPh = curPh;

        // Register write
        wrVal = wrMerge(regVal(st_r, st_r.awAddr), st_r.wData, st_r.wStrb);
        if (st_r.awHeld && st_r.wHeld && !st_r.bValid)
        begin
            st_nxt.awHeld = 1'b0;
            st_nxt.wHeld  = 1'b0;
            st_nxt.bValid = 1'b1;
            st_nxt.bResp  = regHit(st_r.awAddr) ? RESP_OKAY : RESP_DECERR;
            if (regHit(st_r.awAddr))
            begin
                case (st_r.awAddr[4:0])
                    REG_CTRL:
                    begin
                        st_nxt.outSrc   = wrVal[1:0];
                        st_nxt.regenSel = wrVal[CTRL_REGEN];
                        st_nxt.absEn    = wrVal[CTRL_ABSEN];
                    end
                    REG_Z_TRIM:   st_nxt.zTrim = wrVal[14:0];
                    REG_Z_MIN:    st_nxt.zMinUs = (wrVal > 32'(Z_MIN_MAX_US)) ?
                                      Z_MIN_MAX_US : wrVal[8:0];
                    REG_Z_INTV:   st_nxt.zIntv = (wrVal > 32'(Z_INTV_MAX)) ?
                                      Z_INTV_MAX : wrVal[28:0];
                    REG_RP_SPEED: st_nxt.rpSpeed = (wrVal < 32'(SPEED_MIN)) ? SPEED_MIN :
                                      (wrVal > 32'(SPEED_MAX)) ? SPEED_MAX :
                                      wrVal[11:0];
                    REG_RP_PPR:   st_nxt.ppr = wrVal[17:0];
                    default:      st_nxt.bResp = RESP_OKAY;
                endcase
            end
        end
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.awHeld = 1'b1;
            st_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.wHeld = 1'b1;
            st_nxt.wData = s_axi_wdata;
            st_nxt.wStrb = s_axi_wstrb;
        end
        if (st_r.bValid && s_axi_bready)
            st_nxt.bValid = 1'b0;

        // Register read
        if (st_r.rValid && s_axi_rready)
            st_nxt.rValid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            st_nxt.rValid = 1'b1;
            st_nxt.rData  = regVal(st_r, s_axi_araddr);
            st_nxt.rResp  = regHit(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
        end

        // Duty regeneration: step the output phase toward a stable input phase
        if (curPh != st_r.candPh)
        begin
            st_nxt.candPh  = curPh;
            st_nxt.stabCnt = 2'h0;
        end
        else if (st_r.stabCnt != REGEN_STABLE)
            st_nxt.stabCnt = st_r.stabCnt + 2'h1;
        if (!replayOn && st_r.stabCnt == REGEN_STABLE && st_r.outPh != st_r.candPh)
            st_nxt.outPh = (st_r.candPh - st_r.outPh == 2'h3) ? st_r.outPh - 2'h1
                                                               : st_r.outPh + 2'h1;

        // Serial scale zero and periodic phase Z
        st_nxt.posZeroPrev = posZero;
        zRelN = st_r.zRel;
        if (posZero)
            zRelN = 29'h0000000;
        else if (pulseFwd)
            zRelN = (st_r.zRel + 29'h1 >= st_r.zIntv) ? 29'h0 : st_r.zRel + 29'h1;
        else if (pulseRev)
            zRelN = (st_r.zRel == 29'h0) ? st_r.zIntv - 29'h1 : st_r.zRel - 29'h1;
        st_nxt.zRel = zRelN;
        if (posZero)
            st_nxt.zeroSeen = 1'b1;
        zEvt = (st_r.outSrc == SRC_SCALE_SER) &&
               ((posZero && !st_r.posZeroPrev) ||
                (st_r.zIntv != 29'h0 && st_r.zeroSeen && !posZero &&
                 pulseWrap && zRelN == 29'h0));

        // Minimum scale Z width, counted in clock cycles
        zSrc = (st_r.outSrc == SRC_SCALE_AB) ? scaleZ : zEvt;
        st_nxt.zSrcPrev = zSrc;
        if (zSrc && !st_r.zSrcPrev)
            st_nxt.zMinCnt = 16'(16'(st_r.zMinUs) * CYC_PER_US);
        else if (st_r.zMinCnt != 16'h0000)
            st_nxt.zMinCnt = st_r.zMinCnt - 16'h0001;

        // Motor Z width trim in output pulses
        st_nxt.motorZPrev = motorZ;
        if (st_r.motorZPrev && !motorZ)
            st_nxt.trimCnt = st_r.zTrim;
        else if (pulseWrap && st_r.trimCnt != 15'h0000)
            st_nxt.trimCnt = st_r.trimCnt - 15'h0001;

        // Initial absolute position replay
        st_nxt.sensorPrev = sensorOnRequest;
        absMag = absPosition[31] ? 32'(-absPosition) : absPosition;
        rpInc  = 40'({32'(st_r.rpSpeed * st_r.ppr), 2'b00});
        accSum = st_r.acc + rpInc;
        case (st_r.rp)
            RP_IDLE:
            begin
                if (st_r.absEn && sensorOnRequest && !st_r.sensorPrev)
                begin
                    st_nxt.rp     = RP_RUN;
                    st_nxt.rpLeft = {absMag, 2'b00};
                    st_nxt.rpDir  = !absPosition[31];
                    st_nxt.acc    = 40'h00_0000_0000;
                    st_nxt.rpDone = 1'b0;
                end
            end
            RP_RUN:
            begin
                if (st_r.rpLeft == 34'h0)
                begin
                    st_nxt.rp     = RP_IDLE;
                    st_nxt.rpDone = 1'b1;
                end
                else if (accSum >= RP_THRESH)
                begin
                    st_nxt.acc    = accSum - RP_THRESH;
                    st_nxt.rpLeft = st_r.rpLeft - 34'h1;
                    st_nxt.outPh  = st_r.rpDir ? st_r.outPh + 2'h1 : st_r.outPh - 2'h1;
                end
                else
                    st_nxt.acc = accSum;
            end
            default: st_nxt.rp = RP_IDLE;
        endcase

        // Output selection
        if (replayOn || regenOn)
        begin
            st_nxt.outA = st_nxt.outPh[1] ^ st_nxt.outPh[0];
            st_nxt.outB = st_nxt.outPh[1];
        end
        else
        begin
            st_nxt.outA = (st_r.outSrc == SRC_MOTOR) ? motorA : scaleA;
            st_nxt.outB = (st_r.outSrc == SRC_MOTOR) ? motorB : scaleB;
            st_nxt.outPh = curPh;
        end
        if (replayOn)
            st_nxt.outZ = 1'b0;
        else if (st_r.outSrc == SRC_MOTOR)
            st_nxt.outZ = motorZ || (st_nxt.trimCnt != 15'h0000);
        else
            st_nxt.outZ = zSrc || (st_nxt.zMinCnt != 16'h0000);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r         <= '0;
            st_r.absEn   <= ABS_EN_RST;
            st_r.rpSpeed <= SPEED_RST;
            st_r.ppr     <= PPR_RST;
            st_r.rp      <= RP_IDLE;
        end
        else
            st_r <= st_nxt;
    end

    assign s_axi_awready = !st_r.awHeld && !st_r.bValid;
    assign s_axi_wready  = !st_r.wHeld && !st_r.bValid;
    assign s_axi_bvalid  = st_r.bValid;
    assign s_axi_bresp   = st_r.bResp;
    assign s_axi_arready = !st_r.rValid;
    assign s_axi_rvalid  = st_r.rValid;
    assign s_axi_rdata   = st_r.rData;
    assign s_axi_rresp   = st_r.rResp;
    assign pulseOutA     = st_r.outA;
    assign pulseOutB     = st_r.outB;
    assign pulseOutZ     = st_r.outZ;
    assign replayBusy    = (st_r.rp == RP_RUN);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_quiet;
        !replayOn && !(s_axi_awvalid || st_r.awHeld);
    endsequence
    sequence s_serial;
        st_r.outSrc == SRC_SCALE_SER;
    endsequence

    property p_trim_hold;
        s_quiet ##0 (st_r.outSrc == SRC_MOTOR) ##0 (st_nxt.trimCnt != 15'h0000)
            |=> pulseOutZ;
    endproperty
    a_trim_hold: assert property (p_trim_hold) else $error("Z dropped during trim");

    property p_zmin_hold;
        s_quiet ##0 (st_r.outSrc != SRC_MOTOR) ##0 (st_r.zMinCnt > 16'h0001) |=> pulseOutZ;
    endproperty
    a_zmin_hold: assert property (p_zmin_hold) else $error("Z shorter than minimum");

    property p_zmin_load;
        (zSrc && !st_r.zSrcPrev) |=> (st_r.zMinCnt == 16'($past(st_r.zMinUs) * CYC_PER_US));
    endproperty
    a_zmin_load: assert property (p_zmin_load) else $error("Z minimum count wrong");

    property p_zero_only;
        s_serial ##0 (st_r.zIntv == 29'h0) ##0 zEvt |-> posZero;
    endproperty
    a_zero_only: assert property (p_zero_only) else $error("Z away from zero");

    property p_no_z_before_zero;
        s_serial ##0 !st_r.zeroSeen ##0 !posZero |-> !zEvt;
    endproperty
    a_no_z_before_zero: assert property (p_no_z_before_zero) else $error("Z before zero");

    property p_periodic;
        s_serial ##0 zEvt ##0 !posZero |-> (st_r.zIntv != 29'h0) && pulseWrap;
    endproperty
    a_periodic: assert property (p_periodic) else $error("Periodic Z off a pulse");

    property p_passthru;
        (st_r.outSrc == SRC_SCALE_AB) && !st_r.regenSel && !replayOn
            |=> (pulseOutA == $past(scaleA)) && (pulseOutB == $past(scaleB));
    endproperty
    a_passthru: assert property (p_passthru) else $error("A/B not passed through");

    property p_z_through;
        (st_r.outSrc == SRC_SCALE_AB) && !replayOn && scaleZ |=> pulseOutZ;
    endproperty
    a_z_through: assert property (p_z_through) else $error("Scale Z not passed");

    property p_quad;
        (regenOn || replayOn) ##1 (regenOn || replayOn) |->
            !((pulseOutA != $past(pulseOutA)) && (pulseOutB != $past(pulseOutB)));
    endproperty
    a_quad: assert property (p_quad) else $error("A and B changed together");

    property p_replay_start;
        (st_r.rp == RP_IDLE) && st_r.absEn && sensorOnRequest && !st_r.sensorPrev
            |=> replayBusy ##1 (replayBusy || st_r.rpDone);
    endproperty
    a_replay_start: assert property (p_replay_start) else $error("Replay not started");

    property p_replay_end;
        replayOn && (st_r.rpLeft == 34'h0) |=> !replayBusy && st_r.rpDone;
    endproperty
    a_replay_end: assert property (p_replay_end) else $error("Replay not ended");

endmodule : epzo_pulse_out

// >>> design/epzo_pkg.sv
// Constants, register map and state type of the encoder pulse output block.
// Assumes a single 125 MHz clock and an AXI4-Lite master on the register side.
package epzo_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned  CLK_PERIOD_NS = 8;
    localparam int unsigned  NS_PER_US     = 1000;
    localparam longint unsigned NS_PER_S   = 64'd1000000000;
    localparam longint unsigned SEC_PER_MIN = 64'd60;
    localparam logic [15:0]  CYC_PER_US    = 16'(NS_PER_US / CLK_PERIOD_NS);
    localparam logic [39:0]  RP_THRESH     = 40'((NS_PER_S / CLK_PERIOD_NS) * SEC_PER_MIN);
    localparam logic [1:0]   REGEN_STABLE  = 2'h2;

    // ------------------------------------------------------------------
    // Setting ranges and reset values
    // ------------------------------------------------------------------
    localparam logic [8:0]   Z_MIN_MAX_US  = 9'h190;
    localparam logic [28:0]  Z_INTV_MAX    = 29'h1000_0000;
    localparam logic [11:0]  SPEED_MIN     = 12'h3e8;
    localparam logic [11:0]  SPEED_MAX     = 12'hbb8;
    localparam logic [11:0]  SPEED_RST     = 12'h3e8;
    localparam logic [17:0]  PPR_RST       = 18'h00800;

    // ------------------------------------------------------------------
    // Register map (byte offsets) and fields
    // ------------------------------------------------------------------
    localparam logic [4:0]   REG_CTRL      = 5'h00;
    localparam logic [4:0]   REG_Z_TRIM    = 5'h04;
    localparam logic [4:0]   REG_Z_MIN     = 5'h08;
    localparam logic [4:0]   REG_Z_INTV    = 5'h0c;
    localparam logic [4:0]   REG_RP_SPEED  = 5'h10;
    localparam logic [4:0]   REG_RP_PPR    = 5'h14;
    localparam logic [4:0]   REG_STATUS    = 5'h18;
    localparam logic [4:0]   REG_RP_LEFT   = 5'h1c;
    localparam int unsigned  CTRL_REGEN    = 2;
    localparam int unsigned  CTRL_ABSEN    = 3;
    localparam int unsigned  ST_BUSY       = 0;
    localparam int unsigned  ST_ZERO_SEEN  = 1;
    localparam int unsigned  ST_Z_OUT      = 2;
    localparam int unsigned  ST_RP_DONE    = 3;
    localparam logic         ABS_EN_RST    = 1'b1;
    localparam logic [1:0]   SRC_MOTOR     = 2'h0;
    localparam logic [1:0]   SRC_SCALE_AB  = 2'h1;
    localparam logic [1:0]   SRC_SCALE_SER = 2'h2;
    localparam logic [1:0]   RESP_OKAY     = 2'h0;
    localparam logic [1:0]   RESP_DECERR   = 2'h3;

    typedef enum logic [1:0] {RP_IDLE, RP_RUN} epzo_rp_t;

    typedef struct packed {
        logic [1:0]  outSrc;
        logic        regenSel;
        logic        absEn;
        logic [14:0] zTrim;
        logic [8:0]  zMinUs;
        logic [28:0] zIntv;
        logic [11:0] rpSpeed;
        logic [17:0] ppr;
        logic        awHeld;
        logic [31:0] awAddr;
        logic        wHeld;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic [1:0]  inPh;
        logic [1:0]  candPh;
        logic [1:0]  stabCnt;
        logic [1:0]  outPh;
        logic        outA;
        logic        outB;
        logic        outZ;
        logic [14:0] trimCnt;
        logic        motorZPrev;
        logic [15:0] zMinCnt;
        logic        zSrcPrev;
        logic        zeroSeen;
        logic        posZeroPrev;
        logic [28:0] zRel;
        logic        sensorPrev;
        epzo_rp_t    rp;
        logic [39:0] acc;
        logic [33:0] rpLeft;
        logic        rpDir;
        logic        rpDone;
    } epzo_state_t;

endpackage : epzo_pkg

// >>> sim/epzo_host_model.sv
// Host controller model: decodes the quadrature pair and counts phase-Z pulses.
// Assumes the pulse pins are registered device outputs on core_clk.
module epzo_host_model
(
    input  wire logic core_clk,
    input  wire logic pulseA,
    input  wire logic pulseB,
    input  wire logic pulseZ,
    output int        edgeCount,
    output int        zCount
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] prevAb = 2'h0;
    logic       prevZ  = 1'b0;
    // Signed edge count, up when A leads B; an early Z is accepted
    always @(posedge core_clk)
    begin
        if ({pulseA, pulseB} != prevAb)
            edgeCount <= edgeCount + ((pulseA ^ prevAb[0]) ? 1 : -1);
        if (pulseZ && !prevZ)
            zCount <= zCount + 1;
        prevAb <= {pulseA, pulseB};
        prevZ  <= pulseZ;
    end
endmodule : epzo_host_model

// >>> sim/encoder_pulse_output_phase_z_tb_top.sv
// Bench of the encoder pulse output block with a host model on its pins.
// Assumes epzo_pkg, an 8 ns core_clk and the AXI4-Lite register map.
module encoder_pulse_output_phase_z_tb_top
    import epzo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, motorA = 1'b0, motorB = 1'b0, motorZ = 1'b0;
    logic        scaleA = 1'b0, scaleB = 1'b0, scaleZ = 1'b0, sensorOn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, scalePos = 32'h5, absPos = '0;
    logic        awready, wready, bvalid, arready, rvalid, outA, outB, outZ, busy;
    logic [1:0]  bresp, rresp, rsSeen;
    logic [31:0] rdata, rdSeen, seed = 32'h0089;
    logic [4:0]  cA[3] = '{REG_Z_TRIM, REG_Z_MIN, REG_RP_SPEED};
    logic [31:0] cE[3] = '{32'h7fff, 32'h190, 32'hbb8};
    int          miscompares = 0, checks = 0, e0, z0, hi, n, edgeCount, zCount;
    epzo_pulse_out u_dut (.core_clk(core_clk), .nrst(nrst), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .motorA(motorA), .motorB(motorB), .motorZ(motorZ), .scaleA(scaleA),
        .scaleB(scaleB), .scaleZ(scaleZ), .scalePos(scalePos), .absPosition(absPos),
        .sensorOnRequest(sensorOn), .pulseOutA(outA), .pulseOutB(outB), .pulseOutZ(outZ),
        .replayBusy(busy));
    epzo_host_model u_host (.core_clk(core_clk), .pulseA(outA), .pulseB(outB), .pulseZ(outZ),
        .edgeCount(edgeCount), .zCount(zCount));
    initial forever #4 core_clk = ~core_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    // Replay cycles for n pulses at 3000 r/min and 262143 pulses per rev
    function automatic int repCyc(input int n);
        return int'(64'(n) * 64'd7500000000 / (64'd3000 * 64'd262143));
    endfunction : repCyc
    task automatic final_report;
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Handshake seen at the falling edge, taken at the next rising edge
    task automatic waitFor(input int sel);
        logic h;
        do
        begin
            @(negedge core_clk);
            h = (sel == 0) ? arready : (sel == 1) ? rvalid : (sel == 2) ? bvalid
                : (awready && wready);
            @(posedge core_clk);
            rdSeen = rdata;
            rsSeen = (sel == 2) ? bresp : rresp;
        end
        while (!h);
    endtask : waitFor
    task automatic axw(input logic [31:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        waitFor(3);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        waitFor(2);
    endtask : axw
    task automatic axr(input logic [31:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        waitFor(0);
        arvalid <= 1'b0;
        waitFor(1);
    endtask : axr
    // Forward scale quadrature, n phase-A pulses
    task automatic qstep(input int n);
        for (int i = 1; i <= 4 * n; i++)
        begin
            {scaleA, scaleB} <= {i[1] ^ i[0], i[1]};
            repeat (3) @(posedge core_clk);
        end
    endtask : qstep
    initial
    begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        final_report();
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        axr(REG_CTRL);
        chk("ctrl", rdSeen, 32'h8);
        axr(REG_RP_SPEED);
        chk("speed", rdSeen, 32'h3e8);
        axr(32'h20);
        chk("decerr", 32'(rsSeen), 32'(RESP_DECERR));
        axw(32'h20, 32'h0);
        chk("bdecerr", 32'(rsSeen), 32'(RESP_DECERR));
        foreach (cA[i])
        begin
            axw(32'(cA[i]), 32'hffff);
            axr(32'(cA[i]));
            chk("clamp", rdSeen, cE[i]);
        end
        for (int m = 0; m < 2; m++)
        begin
            axw(REG_CTRL, m);
            repeat (16)
            begin
                seed = xs(seed);
                {motorA, motorB, motorZ, scaleA, scaleB} <= {seed[2:0], seed[1:0]};
                @(posedge core_clk);
                @(negedge core_clk);
                chk("ab", 32'({outA, outB}), 32'(m ? seed[1:0] : seed[2:1]));
            end
        end
        {motorA, motorB, motorZ, scaleA, scaleB} <= 5'h0;
        axw(REG_CTRL, 32'h5);
        axw(REG_Z_MIN, 32'h1);
        {scaleA, scaleB, scaleZ} <= 3'h5;
        @(posedge core_clk);
        scaleZ <= 1'b0;
        @(negedge core_clk);
        chk("zFirst", 32'({outZ, outA, outB}), 32'h4);
        hi = 1;
        repeat (200)
        begin
            @(negedge core_clk);
            hi += int'(outZ);
        end
        chk("zWidth", 32'(hi >= 125 && hi <= 127), 32'h1);
        chk("regen", 32'({outA, outB}), 32'h2);
        {scaleA, scaleB} <= 2'h0;
        axw(REG_Z_MIN, 32'h0);
        axw(REG_CTRL, 32'h2);
        for (int k = 0; k < 2; k++)
        begin
            axw(REG_Z_INTV, k ? 32'h0 : 32'h2);
            z0 = zCount;
            qstep(2);
            scalePos <= 32'h0;
            @(posedge core_clk);
            scalePos <= 32'h5;
            qstep(2);
            repeat (4) @(posedge core_clk);
            chk("zCount", 32'(zCount - z0), k ? 32'h1 : 32'h2);
        end
        axw(REG_CTRL, 32'h8);
        axw(REG_RP_SPEED, 32'hbb8);
        axw(REG_RP_PPR, 32'h3ffff);
        seed = xs(seed);
        n = int'(seed[2:0]) + 1;
        absPos <= 32'(n);
        @(posedge core_clk);
        e0 = edgeCount;
        sensorOn <= 1'b1;
        for (hi = 0; hi < 999; hi++)
        begin
            @(negedge core_clk);
            if (hi > 1 && !busy)
                break;
        end
        repeat (2) @(posedge core_clk);
        chk("rpEdges", 32'(edgeCount - e0), 32'(4 * n));
        chk("rpTime", 32'((hi - repCyc(n)) inside {[-4:4]}), 32'h1);
        final_report();
    end
endmodule : encoder_pulse_output_phase_z_tb_top
